// ==== ccas_cfg.svh ====
`ifndef CCAS_CFG_SVH
`define CCAS_CFG_SVH
// register byte offsets
`define CCAS_OFS_OW0     8'h00
`define CCAS_OFS_OWD     8'h04
`define CCAS_OFS_IW0     8'h08
`define CCAS_OFS_IW1     8'h0c
`define CCAS_OFS_BSEL    8'h10
// reset values
`define CCAS_OW0_RST     16'h0000
`define CCAS_OW_RST      8'h00
`define CCAS_RING_SEED   8'h01
// controller addresses and hardwired identifier
`define CCAS_STAT_ADDR   3'h1
`define CCAS_DEV_ID      5'h00
`define CCAS_SEL_ZERO    3'h0
`define CCAS_SEL_NODRV   3'h4
`define CCAS_SEL_SCAN    3'h6
// output word 0 fields
`define CCAS_OW0_SEL     8
`define CCAS_OW0_STRB    11
`define CCAS_OW0_NSFEN   12
`define CCAS_OW0_TMR     13
`define CCAS_OW0_TX_REQUEST_ENABLE   15
// output word 2 / 3 / 4 fields
`define CCAS_OW2_RTS     1
`define CCAS_OW2_ENRRQ   2
`define CCAS_OW2_ENPAR   3
`define CCAS_OW2_STOP    5
`define CCAS_OW2_SELFTST 7
`define CCAS_OW3_CLKSEL  0
`define CCAS_OW3_SYNC    5
`define CCAS_OW3_LEN0    6
`define CCAS_OW3_LEN1    7
`define CCAS_OW4_ALRT    7
// controller status byte fields
`define CCAS_ST_RRQ      0
`define CCAS_ST_THRE     1
`define CCAS_ST_NSF      2
`define CCAS_ST_FILL     3
// ring slots
`define CCAS_SLOT_ADDR1  1
`define CCAS_SLOT_DATA   2
`define CCAS_SLOT_LAST   7
// timing
`define CCAS_CLK_NS      100
`define CCAS_CHAR_NS     300
`define CCAS_TMR_MS      250
`define CCAS_NS_PER_MS   1000000
`endif

// ==== ccas_pkg.sv ====
package ccas_pkg;
  typedef enum logic [1:0] {CYC_IDLE, CYC_SCAN, CYC_WR, CYC_RD} ccas_cyc_t;
  typedef struct packed {
    logic [7:0] dout;
    logic       oe;
    logic       csN;
    logic       weN;
    logic       rdPulseN;
  } ccas_dab_t;
endpackage

// ==== ccas_seq.sv ====
// Contract
// R1: characters of five to eight bits, length set by software.
// R2: async: controller frames start/parity/stop; received parity checked then stripped.
// R3: sync: only parity added on send and stripped on receive.
// R4: parity sits just above the MSB, or replaces the MSB for eight bits.
// R5: one, one and a half or two stop bits from output word 2 bit 5.
// R6: two-part status scan runs continuously; strobe 1 with select 110 forces it.
// R7: scan part one: select pulsed, status address plus zero id on bus.
// R8: scan part two: status byte captured; request and new-status bits meaningful.
// R9: host selects word 0, loads character, then sets strobe to zero.
// R10: host strobe sets busy; next cycle becomes the controller access.
// R11: write cycle: address, write enable, output word driven for 300 ns.
// R12: busy clear resets address to status register and word select to 000.
// R13: read cycle: select, address, read pulse, byte loaded into receive register.
// R14: strobe 1 suppresses scan enables so error status stays valid.
// R15: divider chain with multiplexer selects the baud clock.
// R16: eight-bit one-hot shift ring with decoding sequences every access.
// R17: underrun flagged from fill status, gated by request enable and length bit.
// R18: five output words in latches, selected by word 0 bits 8-10 decoder; the code holds them in clocked flip-flops.
// R19: drivers put inverted words on bus; word 4 never; words 0,1 share.
// R20: software-started 250 ms timer raises an interrupt when it elapses.
// R21: enabled interrupt conditions summarised, signalled, shown in input word 1 bit 14.
// R22: every bit of every input word individually selectable by software.
// R23: self-test and loopback bits pick analog loopback or remote test.
// R24: tx request sets on holding empty with enable, RTS, CTS; clears on write or RTS drop.
// R25: single clock domain, synchronised reset, host strobes synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "ccas_cfg.svh"
module ccas_seq
  import ccas_pkg::*;
#(
  parameter int unsigned TIMER_CYCLES = `CCAS_TMR_MS * (`CCAS_NS_PER_MS / `CCAS_CLK_NS)
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output ccas_dab_t        dab,
  input  wire logic [7:0]  dalIn,
  input  wire logic        ctsIn,
  input  wire logic [7:0]  idSwitch,
  output logic             baudClk,
  output logic             baudClkN,
  output logic             stopBitSel,
  output logic             analogLoop,
  output logic             remoteTest,
  output logic             hostIntN
);
  localparam int WR_CYC = (`CCAS_CHAR_NS + `CCAS_CLK_NS - 1) / `CCAS_CLK_NS;
  localparam int CAP_SLOT = `CCAS_SLOT_DATA + WR_CYC;
  localparam int TW = $clog2(TIMER_CYCLES + 1);

  if (CAP_SLOT >= `CCAS_SLOT_LAST) begin : g_chk_wr
    $error("character cycle does not fit the ring");
  end
  if (TIMER_CYCLES < 2) begin : g_chk_tmr
    $error("timer interval too short");
  end

  function automatic logic [7:0] selDecode(input logic [2:0] s);
    selDecode = 8'h01 << s;
  endfunction

  // mask keeps the low data bits; parity slot cleared as well
  function automatic logic [7:0] rxStrip(input logic [7:0] d, input logic [1:0] len,
                                         input logic par);
    logic [7:0] m;
    m = 8'hff >> (2'h3 - len);
    if (par) begin
      m[(len == 2'h3) ? 3'h7 : (3'h5 + 3'(len))] = 1'b0;
    end
    rxStrip = d & m;
  endfunction

  logic rstMetaQ, rstN;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstMetaQ <= 1'b0;
      rstN     <= 1'b0;
    end else begin
      rstMetaQ <= 1'b1;
      rstN     <= rstMetaQ; // [R25]
    end
  end

  // bus slave: zero-wait writes, one wait state on reads
  logic       dpWrQ, dpRdQ, rdDoneQ;
  logic [7:0] dpAddrQ;
  logic       addrPh;
  assign addrPh    = hsel & htrans[1] & hready;
  assign hreadyout = !(dpRdQ & !rdDoneQ);
  assign hresp     = 1'b0;

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      dpWrQ   <= 1'b0;
      dpRdQ   <= 1'b0;
      rdDoneQ <= 1'b0;
      dpAddrQ <= 8'h00;
    end else begin
      if (hreadyout) begin
        dpWrQ   <= addrPh & hwrite;
        dpRdQ   <= addrPh & !hwrite;
        dpAddrQ <= haddr[7:0];
      end
      rdDoneQ <= dpRdQ & !rdDoneQ;
    end
  end

  logic        wrOw0, wrOwd, wrBsel, rdIw0Done;
  assign wrOw0     = dpWrQ && dpAddrQ == `CCAS_OFS_OW0;
  assign wrOwd     = dpWrQ && dpAddrQ == `CCAS_OFS_OWD;
  assign wrBsel    = dpWrQ && dpAddrQ == `CCAS_OFS_BSEL;
  assign rdIw0Done = dpRdQ && rdDoneQ && dpAddrQ == `CCAS_OFS_IW0;

  // output words and sequencer state
  logic [15:0] ow0Q;
  logic [7:0]  owQ [1:4];
  logic [7:0]  ringQ;
  ccas_cyc_t   cycQ;
  logic        busyQ, cmdReadQ;
  logic [2:0]  addrQ;
  logic [2:0]  sel;
  logic        strobe, cmdEnd, scanEn, strobeRef, newStrobe;
  logic [2:0]  newSel;
  logic [7:0]  owEn;

  assign sel       = ow0Q[`CCAS_OW0_SEL +: 3];
  assign strobe    = ow0Q[`CCAS_OW0_STRB];
  assign newSel    = hwdata[`CCAS_OW0_SEL +: 3];
  assign newStrobe = hwdata[`CCAS_OW0_STRB];
  assign owEn      = selDecode(sel); // [R18]
  assign cmdEnd    = ringQ[`CCAS_SLOT_LAST] & (cycQ == CYC_WR || cycQ == CYC_RD);
  // word 4 and the scan-force code never start a controller access
  assign strobeRef = wrOw0 && newSel != `CCAS_SEL_NODRV && newSel != `CCAS_SEL_SCAN; // [R9]
  assign scanEn    = !strobe || sel == `CCAS_SEL_SCAN; // [R6] [R14]

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      ow0Q <= `CCAS_OW0_RST;
    end else if (wrOw0) begin
      ow0Q <= hwdata[15:0];
    end else begin
      // character load and busy clear touch separate fields, so both may land
      if (wrOwd && owEn[`CCAS_SEL_ZERO]) begin
        ow0Q[7:0] <= hwdata[7:0]; // [R18]
      end
      if (cmdEnd) begin
        ow0Q[`CCAS_OW0_SEL +: 3] <= `CCAS_SEL_ZERO; // [R12]
      end
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 1; i <= 4; i++) begin
        owQ[i] <= `CCAS_OW_RST;
      end
    end else begin
      for (int i = 1; i <= 4; i++) begin
        if (wrOwd && owEn[i]) begin
          owQ[i] <= hwdata[7:0]; // [R18]
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      ringQ <= `CCAS_RING_SEED;
    end else begin
      ringQ <= {ringQ[6:0], ringQ[7]}; // [R16]
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      busyQ    <= 1'b0;
      cmdReadQ <= 1'b0;
    end else if (strobeRef) begin
      busyQ    <= 1'b1; // [R10]
      cmdReadQ <= newStrobe;
    end else if (cmdEnd) begin
      busyQ <= 1'b0; // [R12]
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      cycQ  <= CYC_IDLE;
      addrQ <= `CCAS_STAT_ADDR;
    end else if (ringQ[`CCAS_SLOT_LAST]) begin
      if (busyQ && !cmdEnd) begin
        cycQ  <= cmdReadQ ? CYC_RD : CYC_WR; // [R10]
        addrQ <= sel;
      end else begin
        cycQ  <= scanEn ? CYC_SCAN : CYC_IDLE; // [R6] [R14]
        addrQ <= `CCAS_STAT_ADDR; // [R12]
      end
    end
  end

  // device bus strobes, registered from the ring decode
  logic       inAddr, inData, inCs, active;
  logic [7:0] wrWord;
  assign active = cycQ != CYC_IDLE;
  assign inAddr = |ringQ[`CCAS_SLOT_ADDR1:0];
  assign inData = |ringQ[`CCAS_SLOT_DATA +: WR_CYC];
  assign inCs   = |ringQ[CAP_SLOT:0];

  always_comb begin
    case (addrQ)
      3'h0, 3'h1: wrWord = (addrQ == 3'h0) ? ow0Q[7:0] : owQ[1]; // [R19]
      3'h2:       wrWord = owQ[2];
      3'h3:       wrWord = owQ[3];
      default:    wrWord = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      dab <= '{dout: 8'h00, oe: 1'b0, csN: 1'b1, weN: 1'b1, rdPulseN: 1'b1};
    end else begin
      dab.csN      <= !(active & inCs); // [R7] [R13]
      dab.oe       <= active & (inAddr | (inData & cycQ == CYC_WR));
      dab.weN      <= !(inData & cycQ == CYC_WR); // [R11]
      dab.rdPulseN <= !(inData & (cycQ == CYC_SCAN || cycQ == CYC_RD)); // [R13]
      if (inAddr) begin
        dab.dout <= {`CCAS_DEV_ID, addrQ}; // [R7]
      end else if (inData && cycQ == CYC_WR) begin
        dab.dout <= ~wrWord; // [R11] [R19]
      end
    end
  end

  // capture in the last slot of the registered read pulse, at the edge that ends it
  logic       statusLoadClkN, dataLoadClkN;
  logic [7:0] statQ, rxDataQ;
  assign statusLoadClkN = !(ringQ[CAP_SLOT] && cycQ == CYC_SCAN);
  assign dataLoadClkN   = !(ringQ[CAP_SLOT] && cycQ == CYC_RD);

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      statQ   <= 8'h00;
      rxDataQ <= 8'h00;
    end else begin
      if (!statusLoadClkN) begin
        statQ <= dalIn; // [R8]
      end
      if (!dataLoadClkN) begin
        rxDataQ <= dalIn; // [R13]
      end
    end
  end

  // flags: set wins over clear
  logic rrqQ, wrqQ, nsfQ, underrunQ, timexQ, tmrRunQ, intrSum, charWrite, rts;
  logic [TW-1:0] tmrCntQ;
  logic txRequestEnable, charLenBit1;
  assign txRequestEnable = ow0Q[`CCAS_OW0_TX_REQUEST_ENABLE];
  assign charLenBit1     = owQ[3][`CCAS_OW3_LEN1];
  assign rts             = owQ[2][`CCAS_OW2_RTS];
  assign charWrite       = cmdEnd && cycQ == CYC_WR && addrQ == `CCAS_SEL_ZERO;

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rrqQ      <= 1'b0;
      wrqQ      <= 1'b0;
      nsfQ      <= 1'b0;
      underrunQ <= 1'b0;
    end else begin
      if (!statusLoadClkN && dalIn[`CCAS_ST_RRQ] && owQ[2][`CCAS_OW2_ENRRQ]) begin
        rrqQ <= 1'b1; // [R8]
      end else if (rdIw0Done) begin
        rrqQ <= 1'b0;
      end
      if (!statusLoadClkN && dalIn[`CCAS_ST_THRE] && txRequestEnable && rts && ctsIn) begin
        wrqQ <= 1'b1; // [R24]
      end else if (charWrite || !rts) begin
        wrqQ <= 1'b0; // [R24]
      end
      if (!statusLoadClkN && dalIn[`CCAS_ST_NSF] && ow0Q[`CCAS_OW0_NSFEN]) begin
        nsfQ <= 1'b1;
      end else if (!ow0Q[`CCAS_OW0_NSFEN]) begin
        nsfQ <= 1'b0;
      end
      if (!statusLoadClkN && dalIn[`CCAS_ST_FILL] && txRequestEnable && charLenBit1) begin
        underrunQ <= 1'b1; // [R17]
      end else if (!txRequestEnable) begin
        underrunQ <= 1'b0; // [R17]
      end
    end
  end

  // a 0 to 1 write of the timer bit restarts, a 0 stops and clears
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      tmrRunQ <= 1'b0;
      timexQ  <= 1'b0;
      tmrCntQ <= '0;
    end else if (wrOw0 && hwdata[`CCAS_OW0_TMR] && !ow0Q[`CCAS_OW0_TMR]) begin
      tmrRunQ <= 1'b1; // [R20]
      timexQ  <= 1'b0;
      tmrCntQ <= TW'(TIMER_CYCLES - 1);
    end else if (wrOw0 && !hwdata[`CCAS_OW0_TMR]) begin
      tmrRunQ <= 1'b0;
      timexQ  <= tmrRunQ && tmrCntQ == '0; // expiry in the same cycle still sets
    end else if (tmrRunQ) begin
      if (tmrCntQ == '0) begin
        tmrRunQ <= 1'b0;
        timexQ  <= 1'b1; // [R20]
      end else begin
        tmrCntQ <= tmrCntQ - 1'b1;
      end
    end
  end

  assign intrSum = rrqQ | wrqQ | timexQ | nsfQ; // [R21]
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      hostIntN <= 1'b1;
    end else begin
      hostIntN <= !intrSum; // [R21]
    end
  end

  // baud divider: clock select field picks one stage of the chain
  logic [15:0] baudCntQ;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      baudCntQ <= 16'h0000;
      baudClk  <= 1'b0;
      baudClkN <= 1'b1;
    end else begin
      baudCntQ <= baudCntQ + 16'h0001;
      baudClk  <= baudCntQ[owQ[3][`CCAS_OW3_CLKSEL +: 3]]; // [R15]
      baudClkN <= !baudCntQ[owQ[3][`CCAS_OW3_CLKSEL +: 3]]; // [R15]
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      stopBitSel <= 1'b0;
      analogLoop <= 1'b0;
      remoteTest <= 1'b0;
    end else begin
      stopBitSel <= owQ[2][`CCAS_OW2_STOP]; // [R5] [R2]
      analogLoop <= !owQ[2][`CCAS_OW2_SELFTST] & owQ[4][`CCAS_OW4_ALRT]; // [R23]
      remoteTest <= owQ[2][`CCAS_OW2_SELFTST] & owQ[4][`CCAS_OW4_ALRT]; // [R23]
    end
  end

  // input words and bit-level selection
  logic [7:0]  rxChar;
  logic [15:0] iw [0:4];
  logic [6:0]  bselQ;
  // length code is LEN0:LEN1; parity stripped in sync mode too
  assign rxChar = rxStrip(rxDataQ, {owQ[3][`CCAS_OW3_LEN0], owQ[3][`CCAS_OW3_LEN1]},
                          owQ[2][`CCAS_OW2_ENPAR]); // [R1] [R2] [R3] [R4]
  assign iw[0] = {statQ, rxChar};
  assign iw[1] = {wrqQ, intrSum, timexQ, nsfQ, busyQ, underrunQ, owQ[3][`CCAS_OW3_SYNC],
                  rrqQ, 6'h00, ctsIn, 1'b0};
  assign iw[2] = {8'h00, ~owQ[2][7], owQ[2][6:0]};
  assign iw[3] = {8'h00, owQ[3]};
  assign iw[4] = {8'h00, idSwitch};

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      bselQ <= 7'h00;
    end else if (wrBsel) begin
      bselQ <= hwdata[6:0]; // [R22]
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      hrdata <= 32'h0000_0000;
    end else if (dpRdQ && !rdDoneQ) begin
      case (dpAddrQ)
        `CCAS_OFS_OW0:  hrdata <= {16'h0000, ow0Q};
        `CCAS_OFS_IW0:  hrdata <= {16'h0000, iw[0]};
        `CCAS_OFS_IW1:  hrdata <= {16'h0000, iw[1]};
        `CCAS_OFS_BSEL: hrdata <= {31'h0, (bselQ[6:4] <= 3'h4) &&
                                          iw[bselQ[6:4]][bselQ[3:0]]}; // [R22]
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN);

  logic [3:0] weLowCnt;
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      weLowCnt <= 4'h0;
    end else begin
      weLowCnt <= dab.weN ? 4'h0 : weLowCnt + 4'h1;
    end
  end

  a_ring_onehot:  assert property ($onehot(ringQ)) // [R16]
    else $error("ring counter not one-hot");
  a_busy_to_cmd:  assert property (busyQ && ringQ[7] && !cmdEnd |=> cycQ inside {CYC_WR, CYC_RD}) // [R10]
    else $error("busy did not start a command cycle");
  a_scan_forced:  assert property (ringQ[7] && !(busyQ && !cmdEnd) && strobe && sel == 3'h6
                                   |=> cycQ == CYC_SCAN) // [R6]
    else $error("forced scan missing");
  a_scan_halted:  assert property (ringQ[7] && !busyQ && strobe && sel != 3'h6
                                   |=> cycQ == CYC_IDLE) // [R14]
    else $error("scan ran while strobe held");
  a_we_width:     assert property ($fell(dab.weN) |-> !dab.weN[*3] ##1 dab.weN) // [R11]
    else $error("write enable not one character cycle");
  a_we_count:     assert property (weLowCnt <= 4'h3) // [R11]
    else $error("write enable held too long");
  a_clear_resets: assert property (cmdEnd && !wrOw0 |=> addrQ == 3'h1 && sel == 3'h0) // [R12]
    else $error("busy clear did not reset address");
  a_no_word4:     assert property (cycQ == CYC_WR |-> addrQ != 3'h4) // [R19]
    else $error("output word 4 driven");
  a_wrq_rts:      assert property (!rts && !(!statusLoadClkN && dalIn[1]) |=> !wrqQ) // [R24]
    else $error("tx request survived RTS drop");
  a_intr_out:     assert property (intrSum |=> !hostIntN) // [R21]
    else $error("interrupt not signalled");
  a_rd_capture:   assert property (!dataLoadClkN |-> $past(!dab.rdPulseN) && !dab.csN) // [R13]
    else $error("data load outside read pulse");

  c_scan:  cover property (!statusLoadClkN);
  c_write: cover property (cycQ == CYC_WR && ringQ[0] ##7 cmdEnd);
  c_read:  cover property (!dataLoadClkN);
  c_timer: cover property ($rose(timexQ));
endmodule
`default_nettype wire

// ==== ccas_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ccas_cfg.svh"
module ccas_ctl_model
  import ccas_pkg::*;
(
  input  wire logic       mclk,
  input  wire ccas_dab_t  dab,
  input  wire logic [7:0] statByte,
  input  wire logic [7:0] rxByte,
  output logic [7:0]      dalIn,
  output logic [7:0]      wrByte,
  output logic [7:0]      weCycles,
  output logic [7:0]      csFalls
);
  logic [2:0] regAddr;
  logic       csPrev;
  logic [7:0] weRun;
  logic [7:0] junk;
  initial begin
    regAddr  = 3'h0;
    csPrev   = 1'b1;
    weRun    = 8'h00;
    junk     = 8'h5a;
    wrByte   = 8'h00;
    weCycles = 8'h00;
    csFalls  = 8'h00;
  end
  // address latched at the select edge, so later bus traffic cannot alias it
  always @(posedge mclk) begin
    csPrev <= dab.csN;
    junk   <= ~junk + 8'h01;
    if (csPrev && !dab.csN) begin
      regAddr <= dab.dout[2:0];
      csFalls <= csFalls + 8'h01;
    end
    if (!dab.weN) begin
      wrByte <= ~dab.dout;
      weRun  <= weRun + 8'h01;
    end else if (weRun != 8'h00) begin
      weCycles <= weRun;
      weRun    <= 8'h00;
    end
  end
  // outside the read pulse the bus floats, shown as a pattern that keeps changing
  always_comb begin
    if (!dab.rdPulseN) begin
      dalIn = (regAddr == `CCAS_STAT_ADDR) ? statByte : rxByte;
    end else begin
      dalIn = junk;
    end
  end
endmodule
`default_nettype wire

// ==== comm_controller_access_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module comm_controller_access_sequencer_tb
  import ccas_pkg::*;
();
  typedef struct packed {
    logic [2:0] sel;
    logic [7:0] data;
    logic [2:0] bWord;
    logic [3:0] bBit;
    logic       expBit;
    logic       expStop;
    logic       expAl;
    logic       expRt;
  } ccas_row_t;
  logic        mclk;
  logic        arst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  ccas_dab_t   dab;
  logic [7:0]  dalIn;
  logic [7:0]  statByte;
  logic [7:0]  rxByte;
  logic [7:0]  wrByte;
  logic [7:0]  weCycles;
  logic [7:0]  csFalls;
  logic [7:0]  snap;
  logic        baudClk;
  logic        baudClkN;
  logic        stopBitSel;
  logic        analogLoop;
  logic        remoteTest;
  logic        hostIntN;
  logic        cts;
  logic [31:0] rd;
  int          errCount;
  int          checked;
  localparam logic [7:0] ID_VAL = 8'h96; // arbitrary module id
  ccas_row_t rows [6] = '{
    '{3'h2, 8'h20, 3'h4, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0},
    '{3'h2, 8'h00, 3'h4, 4'h1, 1'b1, 1'b0, 1'b0, 1'b0},
    '{3'h4, 8'h80, 3'h4, 4'h7, 1'b1, 1'b0, 1'b1, 1'b0},
    '{3'h2, 8'h80, 3'h5, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1},
    '{3'h1, 8'h3c, 3'h4, 4'h4, 1'b1, 1'b0, 1'b0, 1'b1},
    '{3'h3, 8'hc0, 3'h4, 4'h2, 1'b1, 1'b0, 1'b0, 1'b1}};
  ccas_seq #(.TIMER_CYCLES(20)) dut_u (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dab(dab), .dalIn(dalIn),
    .ctsIn(cts), .idSwitch(ID_VAL), .baudClk(baudClk), .baudClkN(baudClkN),
    .stopBitSel(stopBitSel), .analogLoop(analogLoop), .remoteTest(remoteTest),
    .hostIntN(hostIntN));
  ccas_ctl_model ctl_u (
    .mclk(mclk), .dab(dab), .statByte(statByte), .rxByte(rxByte), .dalIn(dalIn),
    .wrByte(wrByte), .weCycles(weCycles), .csFalls(csFalls));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic finalReport();
    $display("errors %0d, comparisons %0d", errCount, checked);
    if (errCount == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ready is judged at the falling edge so the rising edge sees a settled value
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(negedge mclk); while (hreadyout !== 1'b1);
    @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(negedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
    @(posedge mclk);
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 30; i++) begin
      xfer(1'b0, 8'h0c, 32'h0);
      if (rd[11] === 1'b0) break;
    end
    check({31'h0, rd[11]}, 32'h0);
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    errCount++;
    finalReport();
  end
  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    statByte = 8'h42;
    rxByte = 8'ha5;
    cts = 1'b1;
    errCount = 0;
    checked = 0;
    repeat (3) @(posedge mclk);
    check({27'h0, hreadyout, dab.oe, dab.csN, hostIntN, baudClkN}, 32'h17);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 40 && dab.csN !== 1'b0; i++) @(negedge mclk);
    check({23'h0, dab.oe, dab.dout}, 32'h101);
    for (int i = 0; i < 4 && dab.rdPulseN !== 1'b0; i++) @(negedge mclk);
    repeat (3) begin
      check({31'h0, dab.rdPulseN}, 32'h0);
      @(negedge mclk);
    end
    check({31'h0, dab.rdPulseN}, 32'h1);
    repeat (4) @(posedge mclk);
    xfer(1'b0, 8'h08, 32'h0);
    check({24'h0, rd[15:8]}, 32'h42);
    foreach (rows[i]) begin
      waitIdle();
      xfer(1'b1, 8'h00, {21'h0, rows[i].sel, 8'h00});
      xfer(1'b1, 8'h04, {24'h0, rows[i].data});
      xfer(1'b1, 8'h10, {25'h0, rows[i].bWord, rows[i].bBit});
      xfer(1'b0, 8'h10, 32'h0);
      check({31'h0, rd[0]}, {31'h0, rows[i].expBit});
      check({29'h0, stopBitSel, analogLoop, remoteTest},
            {29'h0, rows[i].expStop, rows[i].expAl, rows[i].expRt});
    end
    @(negedge mclk);
    snap[0] = baudClk;
    @(negedge mclk);
    check({30'h0, baudClk, baudClkN}, {30'h0, !snap[0], snap[0]});
    waitIdle();
    xfer(1'b1, 8'h00, 32'h0100);
    xfer(1'b0, 8'h0c, 32'h0);
    check({31'h0, rd[11]}, 32'h1);
    waitIdle();
    check({24'h0, wrByte}, 32'h3c);
    check({24'h0, weCycles}, 32'h3);
    xfer(1'b0, 8'h00, 32'h0);
    check({29'h0, rd[10:8]}, 32'h0);
    xfer(1'b1, 8'h00, 32'h0800);
    xfer(1'b0, 8'h0c, 32'h0);
    check({31'h0, rd[11]}, 32'h1);
    waitIdle();
    xfer(1'b0, 8'h08, 32'h0);
    check({24'h0, rd[7:0]}, 32'ha5);
    snap = csFalls;
    repeat (40) @(posedge mclk);
    check({24'h0, csFalls}, {24'h0, snap});
    xfer(1'b1, 8'h00, 32'h0e00);
    repeat (40) @(posedge mclk);
    check({31'h0, csFalls != snap}, 32'h1);
    xfer(1'b1, 8'h20, 32'h1234);
    xfer(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    check({31'h0, hostIntN}, 32'h1);
    xfer(1'b1, 8'h00, 32'h0000);
    xfer(1'b1, 8'h00, 32'h2000);
    for (int i = 0; i < 200 && hostIntN !== 1'b0; i++) @(negedge mclk);
    check({31'h0, hostIntN}, 32'h0);
    xfer(1'b0, 8'h0c, 32'h0);
    check({30'h0, rd[14:13]}, 32'h3);
    xfer(1'b1, 8'h00, 32'h0000);
    repeat (5) @(posedge mclk);
    check({31'h0, hostIntN}, 32'h1);
    // request enable, RTS, parity on; controller reports holding empty and fill
    xfer(1'b1, 8'h00, 32'h8200);
    xfer(1'b1, 8'h04, 32'h008a);
    statByte <= 8'h4a;
    waitIdle();
    repeat (20) @(posedge mclk);
    xfer(1'b0, 8'h0c, 32'h0);
    check({28'h0, rd[15], rd[14], rd[10], rd[1]}, 32'hf);
    xfer(1'b0, 8'h08, 32'h0);
    check({24'h0, rd[7:0]}, 32'h25);
    cts <= 1'b0;
    xfer(1'b1, 8'h00, 32'h0200);
    xfer(1'b1, 8'h04, 32'h0080);
    waitIdle();
    xfer(1'b0, 8'h0c, 32'h0);
    check({28'h0, rd[15], rd[14], rd[10], rd[1]}, 32'h0);
    finalReport();
  end
endmodule
`default_nettype wire
